/* shared/alu_decoder_consts.vh */
`ifndef ALU_DECODER_CONSTS_VH
`define ALU_DECODER_CONSTS_VH

// Format selection fields of the fetched halfword.
`define FMT_SHIFT_TOP     3'b000
`define FMT_ADDSUB_TOP    5'b00011
`define FMT_IMM8_TOP      3'b001
`define FMT_ALU_TOP       6'b010000
`define FMT_HIREG_TOP     6'b010001

// Field positions.
`define RD_LSB            0
`define RS_LSB            3
`define SHAMT_LSB         6
`define IMM_FLAG_BIT      10
`define ADDSUB_OP_BIT     9
`define IMM8_RD_LSB       8
`define ALU_OP_LSB        6
`define HI_SRC_BIT        6
`define HI_DST_BIT        7
`define HI_OP_LSB         8

// Shift-immediate operation codes.
`define SH_LSL            2'b00
`define SH_LSR            2'b01
`define SH_ASR            2'b10

// 8-bit immediate operation codes.
`define I8_MOV            2'b00
`define I8_CMP            2'b01
`define I8_ADD            2'b10
`define I8_SUB            2'b11

// Two-register ALU operation codes.
`define ALU_AND           4'h0
`define ALU_EOR           4'h1
`define ALU_LSL           4'h2
`define ALU_LSR           4'h3
`define ALU_ASR           4'h4
`define ALU_ADC           4'h5
`define ALU_SBC           4'h6
`define ALU_ROR           4'h7
`define ALU_TST           4'h8
`define ALU_NEG           4'h9
`define ALU_CMP           4'hA
`define ALU_CMN           4'hB
`define ALU_ORR           4'hC
`define ALU_MUL           4'hD
`define ALU_BIC           4'hE
`define ALU_MVN           4'hF

// Shared execute operation encoding.
`define XOP_AND           4'h0
`define XOP_EOR           4'h1
`define XOP_LSL           4'h2
`define XOP_LSR           4'h3
`define XOP_ASR           4'h4
`define XOP_ADC           4'h5
`define XOP_SBC           4'h6
`define XOP_ROR           4'h7
`define XOP_ADD           4'h8
`define XOP_SUB           4'h9
`define XOP_ORR           4'hA
`define XOP_MUL           4'hB
`define XOP_BIC           4'hC
`define XOP_MVN           4'hD
`define XOP_MOVB          4'hE

// Flag vector positions: negative, zero, carry, overflow.
`define FLAG_N            3
`define FLAG_Z            2
`define FLAG_C            1
`define FLAG_V            0
`define FLAGS_RESET       4'h0

`endif

/* logic/shift_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "alu_decoder_consts.vh"

// Barrel shifter with 8-bit register-specified amounts and carry out.
module shift_unit (
	input  wire [3:0]  op_i,
	input  wire [31:0] value_i,
	input  wire [7:0]  amount_i,
	input  wire        carry_i,
	output reg  [31:0] result_o,
	output reg         carry_o
);
	reg [63:0] wide;
	reg [4:0]  rot;

	always @* begin
		wide = 64'h0;
		rot = amount_i[4:0];
		result_o = value_i;
		carry_o = carry_i;
		if (amount_i != 8'h00) begin
			case (op_i)
				`XOP_LSL: begin
					wide = {32'h0, value_i} << amount_i;
					result_o = wide[31:0];
					carry_o = (amount_i > 8'h20) ? 1'b0 : wide[32];
				end
				`XOP_LSR: begin
					wide = {value_i, 32'h0} >> amount_i;
					result_o = wide[63:32];
					carry_o = (amount_i > 8'h20) ? 1'b0 : wide[31];
				end
				`XOP_ASR: begin
					wide = $signed({value_i, 32'h0}) >>> ((amount_i > 8'h20) ? 8'h20 : amount_i);
					result_o = wide[63:32];
					carry_o = wide[31];
				end
				`XOP_ROR: begin
					wide = {value_i, value_i} >> rot;
					result_o = wide[31:0];
					carry_o = wide[31];
				end
				default: begin
					result_o = value_i;
					carry_o = carry_i;
				end
			endcase
		end
	end
endmodule

`default_nettype wire

/* logic/flag_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "alu_decoder_consts.vh"

// Adder with flag generation for add, subtract and carry forms.
module flag_unit (
	input  wire [31:0] a_i,
	input  wire [31:0] b_i,
	input  wire        carry_in_i,
	output wire [31:0] sum_o,
	output wire        carry_o,
	output wire        overflow_o
);
	wire [32:0] total;

	assign total = {1'b0, a_i} + {1'b0, b_i} + {32'h0, carry_in_i};
	assign sum_o = total[31:0];
	assign carry_o = total[32];
	assign overflow_o = (a_i[31] == b_i[31]) && (sum_o[31] != a_i[31]);
endmodule

`default_nettype wire

/* logic/compact_isa_alu_decoder.v */
// How it works
// [RULE1] Shift-immediate op 00 shifts source left by 5-bit amount into destination.
// [RULE2] Shift-immediate op 01 shifts source right logically, zero fill.
// [RULE3] Shift-immediate op 10 shifts source right arithmetically, sign fill.
// [RULE4] Every instruction of the four formats updates the status flags.
// [RULE5] Add/subtract op 0, register form: destination gets source plus second register.
// [RULE6] Add/subtract op 0, immediate form: destination gets source plus 3-bit immediate.
// [RULE7] Add/subtract op 1, register form: destination gets source minus second register.
// [RULE8] Add/subtract op 1, immediate form: destination gets source minus 3-bit immediate.
// [RULE9] Byte-immediate op 00 loads the zero-extended byte into the register.
// [RULE10] Byte-immediate op 01 compares register with byte, flags only.
// [RULE11] Byte-immediate op 10 adds the byte to the register.
// [RULE12] Byte-immediate op 11 subtracts the byte from the register.
// [RULE13] Two-register ALU: 4-bit code, destination is first operand and result.
// [RULE14] Bitwise codes: and, exclusive-or, inclusive-or, clear bits, inverted move.
// [RULE15] Register shifts: left, logical right, arithmetic right, rotate right.
// [RULE16] Add with carry and subtract with inverted carry write the destination.
// [RULE17] Bit test, compare and compare-by-sum write only the flags.
// [RULE18] Negate writes zero minus source to the destination.
// [RULE19] Multiply writes the low product word to the destination.
// [RULE20] All forms map onto the one full-width execute path, one cycle each.
// [RULE21] Hi-register format fields: dest 2:0, source 5:3, flags 6 and 7, op 9:8.
// [RULE22] Hi flags act as fourth register-number bit, reaching registers 8 to 15.
// [RULE23] Format chosen by top bits: 000, 00011, 001, 010000.
`timescale 1ns/1ps
`default_nettype none
`include "alu_decoder_consts.vh"

module compact_isa_alu_decoder (
	input  wire        mclk_i,
	input  wire        rst_b_i,
	input  wire        instr_valid_i,
	input  wire [15:0] instr_i,
	input  wire [31:0] rd_data_a_i,
	input  wire [31:0] rd_data_b_i,
	input  wire [3:0]  flags_i,
	output reg  [3:0]  rd_addr_a_o,
	output reg  [3:0]  rd_addr_b_o,
	output reg         wr_en_o,
	output reg  [3:0]  wr_addr_o,
	output reg  [31:0] wr_data_o,
	output reg         flags_wr_o,
	output reg  [3:0]  flags_o,
	output reg         hireg_valid_o,
	output reg  [1:0]  hireg_op_o,
	output reg         undef_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode stage: operand addresses and execute controls.

	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_EXEC = 4'b0010;
	localparam [3:0] ST_HI   = 4'b0100;
	localparam [3:0] ST_BAD  = 4'b1000;

	reg  [3:0]  state;
	reg  [3:0]  xop;
	reg         use_imm;
	reg  [31:0] imm;
	reg         writes;
	reg  [2:0]  dest;
	reg         logic_flags;
	reg         shift_flags;
	reg         dest_is_alu;
	// Opcode of a hi-register halfword, held so it leaves together with its valid pulse.
	reg  [1:0]  hi_op;

	reg  [3:0]  next_state;
	reg  [3:0]  next_xop;
	reg         next_use_imm;
	reg  [31:0] next_imm;
	reg         next_writes;
	reg  [2:0]  next_dest;
	reg  [3:0]  next_addr_a;
	reg  [3:0]  next_addr_b;
	reg         next_logic_flags;
	reg         next_shift_flags;

	function [3:0] lo_reg;
		input [15:0] word;
		input integer lsb;
		begin
			lo_reg = {1'b0, word[lsb +: 3]};
		end
	endfunction

	always @* begin
		next_state = ST_IDLE;
		next_xop = `XOP_ADD;
		next_use_imm = 1'b0;
		next_imm = 32'h0;
		next_writes = 1'b0;
		next_dest = instr_i[`RD_LSB +: 3];
		next_addr_a = lo_reg(instr_i, `RS_LSB);
		next_addr_b = lo_reg(instr_i, `RD_LSB);
		next_logic_flags = 1'b0;
		next_shift_flags = 1'b0;
		if (instr_valid_i) begin
			next_state = ST_EXEC;
			if (instr_i[15:11] == `FMT_ADDSUB_TOP) begin //RULE23
				next_xop = instr_i[`ADDSUB_OP_BIT] ? `XOP_SUB : `XOP_ADD; //RULE5 RULE7
				next_use_imm = instr_i[`IMM_FLAG_BIT]; //RULE6 RULE8
				next_imm = {29'h0, instr_i[8:6]};
				next_addr_b = lo_reg(instr_i, 6);
				next_writes = 1'b1;
			end else if (instr_i[15:13] == `FMT_SHIFT_TOP) begin //RULE23
				case (instr_i[12:11])
					`SH_LSL: next_xop = `XOP_LSL; //RULE1
					`SH_LSR: next_xop = `XOP_LSR; //RULE2
					`SH_ASR: next_xop = `XOP_ASR; //RULE3
					default: next_xop = `XOP_LSL;
				endcase
				next_use_imm = 1'b1;
				// Immediate zero encodes 32 for the right shifts.
				next_imm = (instr_i[10:6] == 5'h00 && instr_i[12:11] != `SH_LSL)
					? 32'h20 : {27'h0, instr_i[10:6]};
				next_shift_flags = 1'b1;
				next_writes = 1'b1;
			end else if (instr_i[15:13] == `FMT_IMM8_TOP) begin //RULE23
				next_dest = instr_i[`IMM8_RD_LSB +: 3];
				next_addr_a = lo_reg(instr_i, `IMM8_RD_LSB);
				next_use_imm = 1'b1;
				next_imm = {24'h0, instr_i[7:0]};
				next_writes = (instr_i[12:11] != `I8_CMP); //RULE10
				case (instr_i[12:11])
					`I8_MOV: next_xop = `XOP_MOVB; //RULE9
					`I8_CMP: next_xop = `XOP_SUB; //RULE10
					`I8_ADD: next_xop = `XOP_ADD; //RULE11
					default: next_xop = `XOP_SUB; //RULE12
				endcase
				next_logic_flags = (instr_i[12:11] == `I8_MOV);
			end else if (instr_i[15:10] == `FMT_ALU_TOP) begin //RULE23
				next_addr_a = lo_reg(instr_i, `RD_LSB); //RULE13
				next_addr_b = lo_reg(instr_i, `RS_LSB);
				next_writes = 1'b1;
				next_logic_flags = 1'b1;
				case (instr_i[`ALU_OP_LSB +: 4])
					`ALU_AND: next_xop = `XOP_AND; //RULE14
					`ALU_EOR: next_xop = `XOP_EOR; //RULE14
					`ALU_LSL: next_xop = `XOP_LSL; //RULE15
					`ALU_LSR: next_xop = `XOP_LSR; //RULE15
					`ALU_ASR: next_xop = `XOP_ASR; //RULE15
					`ALU_ROR: next_xop = `XOP_ROR; //RULE15
					`ALU_ADC: next_xop = `XOP_ADC; //RULE16
					`ALU_SBC: next_xop = `XOP_SBC; //RULE16
					`ALU_ORR: next_xop = `XOP_ORR; //RULE14
					`ALU_MUL: next_xop = `XOP_MUL; //RULE19
					`ALU_BIC: next_xop = `XOP_BIC; //RULE14
					`ALU_MVN: next_xop = `XOP_MVN; //RULE14
					`ALU_TST: begin
						next_xop = `XOP_AND; //RULE17
						next_writes = 1'b0;
					end
					`ALU_CMP: begin
						next_xop = `XOP_SUB; //RULE17
						next_writes = 1'b0;
					end
					`ALU_CMN: begin
						next_xop = `XOP_ADD; //RULE17
						next_writes = 1'b0;
					end
					default: begin
						// Negate is zero minus source; a zero immediate stands first.
						next_xop = `XOP_SUB; //RULE18
						next_use_imm = 1'b1;
					end
				endcase
				case (instr_i[`ALU_OP_LSB +: 4])
					`ALU_LSL, `ALU_LSR, `ALU_ASR, `ALU_ROR: begin
						next_logic_flags = 1'b0;
						next_shift_flags = 1'b1;
					end
					`ALU_ADC, `ALU_SBC, `ALU_NEG, `ALU_CMP, `ALU_CMN: next_logic_flags = 1'b0;
					default: next_logic_flags = 1'b1;
				endcase
			end else if (instr_i[15:10] == `FMT_HIREG_TOP) begin
				next_state = ST_HI;
				next_addr_a = {instr_i[`HI_DST_BIT], instr_i[`RD_LSB +: 3]}; //RULE21 RULE22
				next_addr_b = {instr_i[`HI_SRC_BIT], instr_i[`RS_LSB +: 3]}; //RULE21 RULE22
			end else begin
				next_state = ST_BAD;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Execute stage on the shared full-width path.

	wire [31:0] opnd_a;
	wire [31:0] opnd_b;
	wire [31:0] add_b;
	wire        add_cin;
	wire [31:0] add_a;
	wire [31:0] sum;
	wire        sum_c;
	wire        sum_v;
	wire [31:0] sh_res;
	wire        sh_c;
	wire        is_neg;
	wire [63:0] product;

	// Register-form shifts take the amount from the second operand; the A port is shifted.
	assign opnd_a = rd_data_a_i;
	assign opnd_b = use_imm ? imm : rd_data_b_i;
	assign is_neg = use_imm && (xop == `XOP_SUB) && logic_flags == 1'b0 && imm == 32'h0 && writes && state == ST_EXEC
		&& dest_is_alu;
	assign add_a = is_neg ? 32'h0 : opnd_a;
	assign add_b = (xop == `XOP_SUB || xop == `XOP_SBC) ? ~(is_neg ? rd_data_b_i : opnd_b) : opnd_b;
	assign add_cin = (xop == `XOP_SUB) ? 1'b1 : ((xop == `XOP_ADC || xop == `XOP_SBC) ? flags_i[`FLAG_C] : 1'b0); //RULE16
	assign product = rd_data_a_i * rd_data_b_i;

	flag_unit u_flag (
		.a_i        (add_a),
		.b_i        (add_b),
		.carry_in_i (add_cin),
		.sum_o      (sum),
		.carry_o    (sum_c),
		.overflow_o (sum_v)
	);

	shift_unit u_shift (
		.op_i     (xop),
		.value_i  (opnd_a),
		.amount_i (opnd_b[7:0]),
		.carry_i  (flags_i[`FLAG_C]),
		.result_o (sh_res),
		.carry_o  (sh_c)
	);

	reg [31:0] result;
	reg [3:0]  next_flags;

	always @* begin
		case (xop)
			`XOP_AND: result = opnd_a & opnd_b;
			`XOP_EOR: result = opnd_a ^ opnd_b;
			`XOP_ORR: result = opnd_a | opnd_b;
			`XOP_BIC: result = opnd_a & ~opnd_b;
			`XOP_MVN: result = ~opnd_b;
			`XOP_MUL: result = product[31:0]; //RULE19
			`XOP_MOVB: result = opnd_b;
			`XOP_LSL, `XOP_LSR, `XOP_ASR, `XOP_ROR: result = sh_res;
			default: result = sum;
		endcase
		next_flags = flags_i;
		next_flags[`FLAG_N] = result[31]; //RULE4
		next_flags[`FLAG_Z] = (result == 32'h0); //RULE4
		if (shift_flags) begin
			next_flags[`FLAG_C] = sh_c;
		end else if (!logic_flags) begin
			next_flags[`FLAG_C] = sum_c;
			next_flags[`FLAG_V] = sum_v;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pipeline registers; each instruction completes one cycle after decode.

	always @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
			xop <= `XOP_ADD;
			use_imm <= 1'b0;
			imm <= 32'h0;
			writes <= 1'b0;
			dest <= 3'h0;
			logic_flags <= 1'b0;
			shift_flags <= 1'b0;
			dest_is_alu <= 1'b0;
			hi_op <= 2'b00;
			rd_addr_a_o <= 4'h0;
			rd_addr_b_o <= 4'h0;
			wr_en_o <= 1'b0;
			wr_addr_o <= 4'h0;
			wr_data_o <= 32'h0;
			flags_wr_o <= 1'b0;
			flags_o <= `FLAGS_RESET;
			hireg_valid_o <= 1'b0;
			hireg_op_o <= 2'b00;
			undef_o <= 1'b0;
		end else begin
			state <= next_state;
			xop <= next_xop;
			use_imm <= next_use_imm;
			imm <= next_imm;
			writes <= next_writes;
			dest <= next_dest;
			logic_flags <= next_logic_flags;
			shift_flags <= next_shift_flags;
			dest_is_alu <= instr_valid_i && (instr_i[15:10] == `FMT_ALU_TOP);
			hi_op <= instr_i[`HI_OP_LSB +: 2]; //RULE21
			rd_addr_a_o <= next_addr_a;
			rd_addr_b_o <= next_addr_b;
			wr_en_o <= (state == ST_EXEC) && writes; //RULE20
			wr_addr_o <= {1'b0, dest};
			wr_data_o <= result;
			flags_wr_o <= (state == ST_EXEC); //RULE4
			flags_o <= (state == ST_EXEC) ? next_flags : flags_i;
			hireg_valid_o <= (state == ST_HI);
			hireg_op_o <= hi_op; //RULE21
			undef_o <= (state == ST_BAD);
		end
	end

endmodule

`default_nettype wire

/* tb/alu_decoder_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module alu_decoder_checker (
	input wire logic        mclk_i,
	input wire logic        rst_b_i,
	input wire logic        instr_valid_i,
	input wire logic [15:0] instr_i,
	input wire logic [3:0]  rd_addr_a_o,
	input wire logic [3:0]  rd_addr_b_o,
	input wire logic        wr_en_o,
	input wire logic [3:0]  wr_addr_o,
	input wire logic [31:0] wr_data_o,
	input wire logic        flags_wr_o,
	input wire logic        hireg_valid_o,
	input wire logic        undef_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	wire logic v = instr_valid_i;
	property p_flag_update;
		v && (instr_i[15:14] == 2'h0 || instr_i[15:10] == 6'h10) |-> ##2 flags_wr_o;
	endproperty
	a_flag_update: assert property (p_flag_update) else $error("flags not updated");
	property p_shift_dest;
		logic [2:0] d;
		(v && instr_i[15:13] == 3'h0, d = instr_i[2:0]) |-> ##2 wr_en_o && wr_addr_o == {1'b0, d};
	endproperty
	a_shift_dest: assert property (p_shift_dest) else $error("shift or add destination wrong");
	property p_shift_src;
		logic [2:0] s;
		(v && instr_i[15:13] == 3'h0, s = instr_i[5:3]) |=> rd_addr_a_o == {1'b0, s};
	endproperty
	a_shift_src: assert property (p_shift_src) else $error("source address wrong");
	property p_addsub_second;
		logic [2:0] n;
		(v && instr_i[15:10] == 6'h06, n = instr_i[8:6]) |=> rd_addr_b_o == {1'b0, n};
	endproperty
	a_addsub_second: assert property (p_addsub_second) else $error("second operand address wrong");
	property p_imm8_move;
		logic [7:0] b;
		logic [2:0] d;
		(v && instr_i[15:11] == 5'h04, b = instr_i[7:0], d = instr_i[10:8]) |->
			##2 wr_en_o && wr_addr_o == {1'b0, d} && wr_data_o == {24'h0, b};
	endproperty
	a_imm8_move: assert property (p_imm8_move) else $error("byte move wrong");
	property p_imm8_compare;
		v && instr_i[15:11] == 5'h05 |-> ##2 !wr_en_o && flags_wr_o;
	endproperty
	a_imm8_compare: assert property (p_imm8_compare) else $error("byte compare wrote register");
	property p_alu_flag_only;
		v && instr_i[15:10] == 6'h10 && (instr_i[9:6] == 4'h8 || instr_i[9:7] == 3'h5) |-> ##2 !wr_en_o;
	endproperty
	a_alu_flag_only: assert property (p_alu_flag_only) else $error("flag-only op wrote register");
	property p_hireg;
		logic [3:0] d;
		logic [3:0] s;
		(v && instr_i[15:10] == 6'h11, d = {instr_i[7], instr_i[2:0]}, s = {instr_i[6], instr_i[5:3]}) |->
			##1 rd_addr_a_o == d && rd_addr_b_o == s ##1 hireg_valid_o && !wr_en_o;
	endproperty
	a_hireg: assert property (p_hireg) else $error("hi register fields wrong");
	property p_undef;
		v && instr_i[15] |-> ##2 undef_o && !flags_wr_o && !wr_en_o;
	endproperty
	a_undef: assert property (p_undef) else $error("foreign format not refused");
	property p_write_cause;
		wr_en_o |-> $past(instr_valid_i, 2);
	endproperty
	a_write_cause: assert property (p_write_cause) else $error("write without instruction");
	c_cmp: cover property (p_imm8_compare);
	c_flag_only: cover property (v && instr_i[15:10] == 6'h10 && instr_i[9:6] == 4'h8);
	c_hireg: cover property (v && instr_i[15:10] == 6'h11);
endmodule
bind compact_isa_alu_decoder alu_decoder_checker chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
	.instr_valid_i(instr_valid_i), .instr_i(instr_i), .rd_addr_a_o(rd_addr_a_o), .rd_addr_b_o(rd_addr_b_o),
	.wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .flags_wr_o(flags_wr_o),
	.hireg_valid_o(hireg_valid_o), .undef_o(undef_o));
`default_nettype wire

/* tb/reg_file_model.sv */
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
	input  wire logic        mclk_i,
	input  wire logic [3:0]  rd_addr_a_i,
	input  wire logic [3:0]  rd_addr_b_i,
	input  wire logic        wr_en_i,
	input  wire logic [3:0]  wr_addr_i,
	input  wire logic [31:0] wr_data_i,
	input  wire logic        flags_wr_i,
	input  wire logic [3:0]  flags_i,
	output logic      [31:0] rd_data_a_o,
	output logic      [31:0] rd_data_b_o,
	output logic      [3:0]  flags_o
);
	logic [31:0] regs [0:15];
	// Reads are combinational so operands arrive in the cycle the addresses do.
	assign rd_data_a_o = regs[rd_addr_a_i];
	assign rd_data_b_o = regs[rd_addr_b_i];
	always @(posedge mclk_i) begin
		if (wr_en_i)
			regs[wr_addr_i] <= wr_data_i;
		if (flags_wr_i)
			flags_o <= flags_i;
	end
	task set_reg(input int idx, input logic [31:0] val);
		regs[idx] = val;
	endtask
	task set_flags(input logic [3:0] val);
		flags_o = val;
	endtask
endmodule
`default_nettype wire

/* tb/test_compact_isa_alu_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_compact_isa_alu_decoder;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [31:0] data_a, data_b, wr_data;
	logic [3:0]  flags_cur, addr_a, addr_b, wr_addr, flags_new;
	logic        wr_en, flags_wr, hireg_valid, undef;
	logic [1:0]  hireg_op;
	int          bad_count = 0;
	int          total_checks = 0;
	always #2.5 mclk = ~mclk;
	compact_isa_alu_decoder dut (.mclk_i(mclk), .rst_b_i(rst_b), .instr_valid_i(valid), .instr_i(instr),
		.rd_data_a_i(data_a), .rd_data_b_i(data_b), .flags_i(flags_cur), .rd_addr_a_o(addr_a),
		.rd_addr_b_o(addr_b), .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
		.flags_wr_o(flags_wr), .flags_o(flags_new), .hireg_valid_o(hireg_valid), .hireg_op_o(hireg_op),
		.undef_o(undef));
	reg_file_model rf (.mclk_i(mclk), .rd_addr_a_i(addr_a), .rd_addr_b_i(addr_b), .wr_en_i(wr_en),
		.wr_addr_i(wr_addr), .wr_data_i(wr_data), .flags_wr_i(flags_wr), .flags_i(flags_new),
		.rd_data_a_o(data_a), .rd_data_b_o(data_b), .flags_o(flags_cur));
	////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task final_report;
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Presents one halfword and returns one cycle later, with the addresses on show.
	task issue(input logic [15:0] ins);
		instr = ins;
		valid = 1'b1;
		@(posedge mclk);
		#1 valid = 1'b0;
	endtask
	// Issues, then judges the results in the cycle they stand, then lets the write land.
	task run(input logic [15:0] ins, input logic ew, input logic [3:0] ea, input logic [31:0] ed,
		input logic [3:0] ef);
		issue(ins);
		@(posedge mclk);
		#1 chk("write enable", ew, wr_en);
		chk("flag write", 1'b1, flags_wr);
		chk("flags", ef, flags_new);
		if (ew) begin
			chk("write address", ea, wr_addr);
			chk("write data", ed, wr_data);
		end
		@(posedge mclk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	task shift_imm;
		rf.set_reg(5, 32'h80000001);
		rf.set_flags(4'h0);
		run(16'h006A, 1'b1, 4'h2, 32'h00000002, 4'h2);
		run(16'h0EEA, 1'b1, 4'h2, 32'h00000010, 4'h0);
		run(16'h112B, 1'b1, 4'h3, 32'hF8000000, 4'h8);
	endtask
	task add_sub;
		rf.set_reg(3, 32'h00000005);
		rf.set_reg(4, 32'h00000007);
		run(16'h1918, 1'b1, 4'h0, 32'h0000000C, 4'h0);
		run(16'h1DD9, 1'b1, 4'h1, 32'h0000000C, 4'h0);
		run(16'h1B1E, 1'b1, 4'h6, 32'hFFFFFFFE, 4'h8);
		run(16'h1F5E, 1'b1, 4'h6, 32'h00000000, 4'h6);
	endtask
	task byte_imm;
		run(16'h2080, 1'b1, 4'h0, 32'h00000080, 4'h2);
		run(16'h2880, 1'b0, 4'h0, 32'h0, 4'h6);
		chk("register after compare", 32'h00000080, rf.regs[0]);
		run(16'h31FF, 1'b1, 4'h1, 32'h0000010B, 4'h0);
		run(16'h3E91, 1'b1, 4'h6, 32'hFFFFFF6F, 4'h8);
	endtask
	task alu_all;
		logic [31:0] res [0:15];
		logic [3:0]  flg [0:15];
		logic [15:0] wmask;
		res = '{32'h3, 32'h8000000C, 32'h78, 32'h10000001, 32'hF0000001, 32'h80000013, 32'h8000000C,
			32'hF0000001, 32'h0, 32'hFFFFFFFD, 32'h0, 32'h0, 32'h8000000F, 32'h8000002D, 32'h8000000C,
			32'hFFFFFFFC};
		flg = '{4'h2, 4'hA, 4'h0, 4'h2, 4'hA, 4'h8, 4'hA, 4'hA, 4'h2, 4'h8, 4'hA, 4'h8, 4'hA, 4'hA, 4'hA, 4'hA};
		wmask = 16'hF2FF;
		for (int op = 0; op < 16; op++) begin
			rf.set_reg(1, 32'h8000000F);
			rf.set_reg(2, 32'h00000003);
			rf.set_flags(4'h2);
			run({6'h10, op[3:0], 3'h2, 3'h1}, wmask[op], 4'h1, res[op], flg[op]);
		end
	endtask
	task hireg_undef;
		issue(16'h4491);
		chk("hi dest address", 4'h9, addr_a);
		chk("hi source address", 4'h2, addr_b);
		@(posedge mclk);
		#1 chk("hi seen", 1'b1, hireg_valid);
		chk("hi write", 1'b0, wr_en);
		chk("hi op", 2'h0, hireg_op);
		issue(16'h4658);
		chk("hi source address", 4'hB, addr_b);
		@(posedge mclk);
		#1 chk("hi op", 2'h2, hireg_op);
		issue(16'hE000);
		@(posedge mclk);
		#1 chk("refused", 1'b1, undef);
		chk("refused flags", 1'b0, flags_wr);
		@(posedge mclk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge mclk);
		#1 rst_b = 1'b1;
		shift_imm();
		add_sub();
		byte_imm();
		alu_all();
		hireg_undef();
		final_report();
	end
endmodule
`default_nettype wire
